// ### src/edbg_top.v
`default_nettype none
`include "edbg_consts.vh"

module edbg_top (
  input wire CLK, // Processor clock, 20 MHz
  input wire RESET_N, // Synchronous reset, low active
  input wire BUS_REQUEST_N, // External bus request pin, low active
  output wire BUS_GRANT_N, // Bus grant, low active
  output wire GRANT_HANG_N, // Grant hang, low active
  input wire GO_MODE, // Keep running while bus granted
  input wire CORE_REQ, // Core wants a data memory access
  input wire CORE_WRITE, // Access is a write
  input wire [`EDBG_ADDR_W-1:0] CORE_ADDR, // Access address
  input wire [`EDBG_DATA_W-1:0] CORE_WDATA, // Write data
  output wire CORE_DONE, // Access finished this cycle
  output reg [`EDBG_DATA_W-1:0] CORE_RDATA, // Read data
  output wire CORE_HALT, // Core execution halted
  output wire CREG_SEL, // Access targets internal control registers
  output wire RAM_SEL, // Access targets internal data RAM
  input wire [`EDBG_DATA_W-1:0] INT_RDATA, // Read data from internal space
  output reg [`EDBG_ADDR_W-1:0] ADDR_OUT, // External address lines
  output wire ADDR_OE, // Address lines driven
  output reg [`EDBG_EXT_W-1:0] DATA_OUT, // External data lines out
  output wire DATA_OE, // Data lines driven
  input wire [`EDBG_EXT_W-1:0] DATA_IN, // External data lines in
  output reg DATA_MEM_SELECT_N, // Data memory select
  output wire PROG_MEM_SELECT_N, // Program memory select, idle here
  output wire BOOT_MEM_SELECT_N, // Boot memory select, idle here
  output reg RD_N, // Read strobe
  output reg WR_N, // Write strobe
  output wire CTRL_OE, // Selects and strobes driven
  input wire WAIT_CFG_WE, // Load zone wait counts
  input wire [3*`EDBG_WAIT_W-1:0] WAIT_CFG_WDATA // Packed zone wait counts
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  localparam ST_IDLE = 2'b00;
  localparam ST_ACCESS = 2'b01;
  localparam ST_GRANT = 2'b10;

  // Classify a data address into internal space or a zone
  function [`EDBG_TGT_W-1:0] decode_target;
    input [`EDBG_ADDR_W-1:0] a;
    begin
      if (a >= `EDBG_CREG_BASE) begin
        decode_target = `EDBG_TGT_CREG;
      end else if (a >= `EDBG_RAM_BASE) begin
        decode_target = `EDBG_TGT_RAM;
      end else if (a >= `EDBG_ZONE2_BASE) begin
        decode_target = `EDBG_TGT_ZONE2;
      end else if (a >= `EDBG_ZONE1_BASE) begin
        decode_target = `EDBG_TGT_ZONE1;
      end else begin
        decode_target = `EDBG_TGT_ZONE0;
      end
    end
  endfunction

  wire [`EDBG_TGT_W-1:0] req_target;
  wire req_internal;
  wire req_external;

  assign RAM_SEL = CORE_REQ && (req_target == `EDBG_TGT_RAM);
  assign CREG_SEL = CORE_REQ && (req_target == `EDBG_TGT_CREG);
  assign req_target = decode_target(CORE_ADDR);
  assign req_internal = RAM_SEL || CREG_SEL;
  assign req_external = CORE_REQ && !req_internal;

  ////////////////////////////////////////////////////////////////////////////
  // Request synchroniser and wait configuration

  wire bus_request_sync_n;
  wire [3*`EDBG_WAIT_W-1:0] zone_wait_config;
  wire bus_req;

  edbg_sync u_sync (
    .clk(CLK),
    .reset_n(1'b1),
    .async_in(BUS_REQUEST_N),
    .sync_out(bus_request_sync_n)
  );

  assign bus_req = !bus_request_sync_n;

  edbg_wait_cfg u_wait (
    .clk(CLK),
    .reset_n(RESET_N),
    .cfg_we(WAIT_CFG_WE),
    .cfg_wdata(WAIT_CFG_WDATA),
    .zone_wait_config(zone_wait_config)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and access sequencing

  reg [1:0] state;
  reg [1:0] next_state;
  reg [`EDBG_WAIT_W-1:0] wait_cnt;
  reg [`EDBG_WAIT_W-1:0] next_wait_cnt;
  reg acc_write;
  reg [`EDBG_TGT_W-1:0] acc_zone;
  reg hang;
  reg done;
  wire [`EDBG_WAIT_W-1:0] zone_waits;

  assign zone_waits = zone_wait_config[req_target[1:0]*`EDBG_WAIT_W +: `EDBG_WAIT_W];

  // Next state of the arbiter
  always @* begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    case (state)
      ST_IDLE: begin
        if (bus_req) begin
          next_state = ST_GRANT;
        end else if (req_external) begin
          next_state = ST_ACCESS;
          next_wait_cnt = zone_waits;
        end
      end
      ST_ACCESS: begin
        if (wait_cnt != {`EDBG_WAIT_W{1'b0}}) begin
          next_wait_cnt = wait_cnt - 1'b1;
        end else if (bus_req) begin
          next_state = ST_GRANT;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_GRANT: begin
        if (!bus_req) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State registers; arbiter keeps running under reset
  always @(posedge CLK) begin
    if (!RESET_N && !bus_req) begin
      state <= ST_IDLE;
      wait_cnt <= {`EDBG_WAIT_W{1'b0}};
    end else if (!RESET_N) begin
      state <= ST_GRANT;
      wait_cnt <= {`EDBG_WAIT_W{1'b0}};
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // Latch the external cycle's address, data and direction
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ADDR_OUT <= {`EDBG_ADDR_W{1'b0}};
      DATA_OUT <= {`EDBG_EXT_W{1'b0}};
      acc_write <= 1'b0;
      acc_zone <= `EDBG_TGT_ZONE0;
    end else if (state == ST_IDLE && next_state == ST_ACCESS) begin
      ADDR_OUT <= CORE_ADDR;
      DATA_OUT <= {CORE_WDATA, {`EDBG_DLANE_LO{1'b0}}};
      acc_write <= CORE_WRITE;
      acc_zone <= req_target;
    end
  end

  // Selects and strobes, registered
  always @(posedge CLK) begin
    if (!RESET_N) begin
      DATA_MEM_SELECT_N <= 1'b1;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
    end else begin
      DATA_MEM_SELECT_N <= !(next_state == ST_ACCESS);
      RD_N <= !(next_state == ST_ACCESS && !next_write(1'b0));
      WR_N <= !(next_state == ST_ACCESS && next_write(1'b0));
    end
  end

  // Direction of the access being entered or continued
  function next_write;
    input dummy;
    begin
      next_write = (state == ST_IDLE) ? CORE_WRITE : acc_write;
    end
  endfunction

  // Completion pulse and read data capture
  always @(posedge CLK) begin
    if (!RESET_N) begin
      done <= 1'b0;
      CORE_RDATA <= {`EDBG_DATA_W{1'b0}};
    end else begin
      done <= 1'b0;
      if (state == ST_ACCESS && wait_cnt == {`EDBG_WAIT_W{1'b0}}) begin
        done <= 1'b1;
        if (!acc_write) begin
          CORE_RDATA <= DATA_IN[`EDBG_EXT_W-1:`EDBG_DLANE_LO];
        end
      end else if (CORE_REQ && req_internal && !done) begin
        done <= 1'b1;
        CORE_RDATA <= INT_RDATA;
      end
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      hang <= 1'b0;
    end else if (state == ST_GRANT && req_external) begin
      hang <= 1'b1;
    end else if (state == ST_ACCESS && wait_cnt == {`EDBG_WAIT_W{1'b0}}) begin
      hang <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  wire granted;
  assign granted = (state == ST_GRANT);

  assign BUS_GRANT_N = !granted;
  assign ADDR_OE = !granted;
  assign CTRL_OE = !granted;
  assign DATA_OE = !granted && (state == ST_ACCESS) && acc_write;
  assign PROG_MEM_SELECT_N = 1'b1;
  assign BOOT_MEM_SELECT_N = 1'b1;
  assign GRANT_HANG_N = !hang;
  assign CORE_DONE = done;
  assign CORE_HALT = granted && (!GO_MODE || req_external);

endmodule
`default_nettype wire

// ### src/edbg_consts.vh
`ifndef EDBG_CONSTS_VH
`define EDBG_CONSTS_VH
// Address and data widths
`define EDBG_ADDR_W 14
`define EDBG_DATA_W 16
`define EDBG_EXT_W 24
`define EDBG_DLANE_LO 8
// Data memory map
`define EDBG_RAM_BASE 14'h3000
`define EDBG_RAM_TOP 14'h37FF
`define EDBG_CREG_BASE 14'h3800
`define EDBG_CREG_TOP 14'h3FFF
// External zone bounds
`define EDBG_ZONE1_BASE 14'h0800
`define EDBG_ZONE2_BASE 14'h2000
// Wait states
`define EDBG_WAIT_W 3
`define EDBG_WAIT_RESET 3'h7
`define EDBG_ZONE_CNT 3
// Decoder result codes
`define EDBG_TGT_W 3
`define EDBG_TGT_ZONE0 3'h0
`define EDBG_TGT_ZONE1 3'h1
`define EDBG_TGT_ZONE2 3'h2
`define EDBG_TGT_RAM 3'h3
`define EDBG_TGT_CREG 3'h4
`endif

// ### src/edbg_sync.v
`default_nettype none
`include "edbg_consts.vh"

module edbg_sync (
  input wire clk, // Processor clock
  input wire reset_n, // Synchronous reset, low active
  input wire async_in, // Level from a pin
  output reg sync_out // Synchronised level
);

  reg stage1;

  // Two flops; first stage read only by the second
  always @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ### src/edbg_wait_cfg.v
`default_nettype none
`include "edbg_consts.vh"

module edbg_wait_cfg (
  input wire clk, // Processor clock
  input wire reset_n, // Synchronous reset, low active
  input wire cfg_we, // Write strobe for wait configuration
  input wire [3*`EDBG_WAIT_W-1:0] cfg_wdata, // Three packed zone wait counts
  output wire [3*`EDBG_WAIT_W-1:0] zone_wait_config // Current packed counts
);

  reg [3*`EDBG_WAIT_W-1:0] waits;

  genvar g;
  generate
    for (g = 0; g < `EDBG_ZONE_CNT; g = g + 1) begin : g_zone
      always @(posedge clk) begin
        if (!reset_n) begin
          waits[g*`EDBG_WAIT_W +: `EDBG_WAIT_W] <= `EDBG_WAIT_RESET;
        end else if (cfg_we) begin
          waits[g*`EDBG_WAIT_W +: `EDBG_WAIT_W] <= cfg_wdata[g*`EDBG_WAIT_W +: `EDBG_WAIT_W];
        end
      end
    end
  endgenerate

  assign zone_wait_config = waits;

endmodule
`default_nettype wire

// ### tb/edbg_top_chk.sv
`default_nettype none
module edbg_chk (
  input wire CLK, // Clock
  input wire RESET_N, // Reset
  input wire BUS_REQUEST_N, // Request pin
  input wire BUS_GRANT_N, // Grant
  input wire GRANT_HANG_N, // Hang
  input wire GO_MODE, // Run under grant
  input wire CORE_REQ, // Core access
  input wire [13:0] CORE_ADDR, // Core address
  input wire CORE_DONE, // Access done
  input wire CORE_HALT, // Core halted
  input wire CREG_SEL, // Control space
  input wire RAM_SEL, // Internal RAM
  input wire [13:0] ADDR_OUT, // Address lines
  input wire ADDR_OE, // Address driven
  input wire [23:0] DATA_OUT, // Data lines
  input wire DATA_OE, // Data driven
  input wire DATA_MEM_SELECT_N, // Data select
  input wire RD_N, // Read strobe
  input wire WR_N, // Write strobe
  input wire CTRL_OE // Strobes driven
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] req_cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Cycles with request held low
  always @(posedge CLK) begin
    if (!RESET_N || BUS_REQUEST_N) req_cnt <= 5'h00;
    else if (req_cnt != 5'h1f) req_cnt <= req_cnt + 5'h01;
  end
  ////////////////////////////////////////
  // grant, halt, strobe, lane, address and hang properties
  a_grant_floats: assert property (!BUS_GRANT_N |-> !ADDR_OE && !CTRL_OE && !DATA_OE)
    else $error("drivers on under grant");
  a_halt_grant: assert property (!BUS_GRANT_N && !GO_MODE |-> CORE_HALT)
    else $error("core runs under grant");
  a_strobe_qual: assert property (!RD_N || !WR_N |-> !DATA_MEM_SELECT_N && (RD_N || WR_N))
    else $error("strobe without select");
  a_low_lanes: assert property (!WR_N |-> DATA_OE && DATA_OUT[7:0] == 8'h00)
    else $error("write lanes wrong");
  a_addr_match: assert property ($fell(DATA_MEM_SELECT_N) |-> ADDR_OUT == $past(CORE_ADDR))
    else $error("address mismatch");
  a_grant_bound: assert property (req_cnt == 5'h10 |-> !BUS_GRANT_N)
    else $error("grant too late");
  a_hang_raise: assert property (!BUS_GRANT_N && GO_MODE && CORE_REQ && !CORE_DONE &&
    !RAM_SEL && !CREG_SEL |-> ##[1:2] !GRANT_HANG_N) else $error("hang missing");
  a_hang_clear: assert property ($rose(GRANT_HANG_N) |-> CORE_DONE || $past(CORE_DONE))
    else $error("hang cleared early");
  c_grant: cover property (!BUS_GRANT_N);
  c_hang: cover property (!GRANT_HANG_N);
  c_write: cover property (!WR_N);
endmodule
bind edbg_top edbg_chk u_chk (.*);
`default_nettype wire

// ### tb/edbg_far.sv
`default_nettype none
module edbg_far (
  input wire clk, // Clock
  input wire [13:0] addr, // Address lines
  input wire [23:0] dout, // Lines from device
  input wire sel_n, // Data select
  input wire rd_n, // Read strobe
  input wire wr_n, // Write strobe
  input wire hang_n, // Grant hang
  input wire want, // Bench wants the bus
  output logic [23:0] din, // Lines to device
  output wire req_n // Bus request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16384];
  logic [23:0] last = 24'h00_0000;
  logic hung = 1'b0;
  // drop request on hang, write only under select
  always @(posedge clk) begin
    if (!want) hung <= 1'b0;
    else if (!hang_n) hung <= 1'b1;
    if (!sel_n && !wr_n) mem[addr] <= dout[23:8];
    if (!sel_n && !rd_n) last <= din;
  end
  assign req_n = !(want && !hung);
  // word on upper lanes, junk below, inverse when released
  always @* begin
    if (!sel_n && !rd_n) din = {mem[addr], 8'h5a};
    else din = ~last;
  end
endmodule
`default_nettype wire

// ### tb/test_external_data_bus_grant.sv
`default_nettype none
module test_external_data_bus_grant;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RESET_N = 0, GO_MODE = 0, CORE_REQ = 0, CORE_WRITE = 0, WAIT_CFG_WE = 0;
  logic [13:0] CORE_ADDR = 0, a;
  logic [15:0] CORE_WDATA = 0, INT_RDATA = 0;
  logic [8:0] WAIT_CFG_WDATA = 0;
  logic want = 0;
  logic [31:0] rs = 32'hd78d;
  logic [13:0] cn [9] = '{14'h07ff, 14'h0800, 14'h1fff, 14'h2000, 14'h2fff, 14'h3000,
    14'h37ff, 14'h3800, 14'h3fff};
  wire BUS_REQUEST_N, BUS_GRANT_N, GRANT_HANG_N, CORE_DONE, CORE_HALT, CREG_SEL, RAM_SEL;
  wire ADDR_OE, DATA_OE, DATA_MEM_SELECT_N, PROG_MEM_SELECT_N, BOOT_MEM_SELECT_N;
  wire RD_N, WR_N, CTRL_OE;
  wire [15:0] CORE_RDATA;
  wire [13:0] ADDR_OUT;
  wire [23:0] DATA_OUT, DATA_IN;
  int n_mismatch = 0, cmp_count = 0, n, m;
  time t_d, t_g;
  always #25 CLK = ~CLK;
  edbg_top dut (.*);
  edbg_far far (.clk(CLK), .addr(ADDR_OUT), .dout(DATA_OUT), .sel_n(DATA_MEM_SELECT_N),
    .rd_n(RD_N), .wr_n(WR_N), .hang_n(GRANT_HANG_N), .want(want), .din(DATA_IN),
    .req_n(BUS_REQUEST_N));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Expected edges from drive to done
  function automatic int lat(input logic [13:0] ad, input logic [8:0] w);
    if (ad >= 14'h3000) return 1;
    if (ad >= 14'h2000) return w[8:6] + 2;
    if (ad >= 14'h0800) return w[5:3] + 2;
    return w[2:0] + 2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One core access, counts edges until done
  task automatic acc(input logic w, input logic [13:0] ad, input logic [15:0] d);
    CORE_REQ = 1;
    CORE_WRITE = w;
    CORE_ADDR = ad;
    CORE_WDATA = d;
    n = 0;
    do begin
      @(posedge CLK);
      #5;
      n++;
    end while (CORE_DONE !== 1'b1 && n < 60);
    t_d = $time;
    chk({CREG_SEL, RAM_SEL}, {ad[13:11] == 3'h7, ad[13:11] == 3'h6});
    CORE_REQ = 0;
    @(posedge CLK);
    #5;
  endtask
  task automatic wait_gnt(input logic v);
    m = 0;
    do begin
      @(posedge CLK);
      #5;
      m++;
    end while (BUS_GRANT_N !== v && m < 40);
  endtask
  task automatic cfg(input logic [8:0] w);
    WAIT_CFG_WDATA = w;
    WAIT_CFG_WE = 1;
    @(posedge CLK);
    #5;
    WAIT_CFG_WE = 0;
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    want = 1;
    repeat (4) @(posedge CLK);
    #5;
    chk(BUS_GRANT_N, 0);
    RESET_N = 1;
    want = 0;
    wait_gnt(1);
    chk(m <= 4, 1);
    acc(1, 14'h0122, 16'hbeef);
    chk(n, 9);
    acc(0, 14'h0122, 0);
    chk(n, 9);
    chk(CORE_RDATA, 16'hbeef);
    $display("reset tests done");
    want = 1;
    wait_gnt(0);
    chk(m, 3);
    chk(CORE_HALT, 1);
    want = 0;
    wait_gnt(1);
    chk(BUS_GRANT_N, 1);
    // zones, map corners and random traffic
    for (int i = 0; i < 30; i++) begin
      rs = xs(rs);
      if (i % 6 == 0) cfg((i == 0) ? 9'h1c0 : rs[8:0]);
      a = (i < 9) ? cn[i] : {rs[29:17], 1'b1};
      INT_RDATA = rs[31:16];
      acc(1, a, rs[15:0]);
      chk(n, lat(a, WAIT_CFG_WDATA));
      acc(0, a, 0);
      chk(n, lat(a, WAIT_CFG_WDATA));
      chk(CORE_RDATA, (a >= 14'h3000) ? INT_RDATA : rs[15:0]);
    end
    $display("zone tests done");
    cfg(9'h1ff);
    fork
      acc(0, 14'h0122, 0);
      begin
        repeat (2) @(posedge CLK);
        #5;
        want = 1;
        wait_gnt(0);
        t_g = $time;
      end
    join
    chk(t_g == t_d, 1);
    chk(t_g - t_d <= 150, 1);
    want = 0;
    wait_gnt(1);
    $display("handoff test done");
    GO_MODE = 1;
    want = 1;
    wait_gnt(0);
    chk(CORE_HALT, 0);
    acc(0, 14'h0122, 0);
    chk(n > 10, 1);
    chk(CORE_RDATA, 16'hbeef);
    chk(GRANT_HANG_N, 1);
    chk(BUS_GRANT_N, 1);
    want = 0;
    GO_MODE = 0;
    $display("hang test done");
    test_done;
  end
  // Watchdog for a hung run
  initial begin
    #500000;
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
